// >>> shared/hb_serial_pkg.sv
// Constants and types shared by the half-bridge serial control block.
package hb_serial_pkg;
	localparam int word_bits = 16;
	localparam int bridge_count = 10;
	localparam int low_group_count = 6;
	localparam int high_group_count = 4;
	// Command word field positions.
	localparam int status_clear_request_pos = 15;
	localparam int group_select_pos = 14;
	localparam int openload_shutdown_enable_pos = 13;
	localparam int low_active_lsb = 7;
	localparam int high_active_lsb = 7;
	localparam int low_high_side_lsb = 1;
	localparam int high_high_side_lsb = 1;
	localparam int supply_overvoltage_lock_enable_pos = 0;
	// Values after reset.
	localparam logic [15:0] command_reset = 16'h0000;
	localparam logic [9:0] bridge_reset = 10'h000;
	localparam logic [3:0] bit_count_reset = 4'h0;
	// Frame events carried across the clock boundary.
	typedef enum logic [1:0] {
		frame_idle,
		frame_good,
		frame_bad
	} frame_result_t;
endpackage

// >>> src/half_bridge_serial_control.sv
// Serial control of a ten-channel half-bridge driver.
//
// Behaviour
// - Frame starts at select falling edge.
// - New command applied at select rising edge.
// - Input bits sampled on clock falling edge.
// - Good frame loads last sixteen bits.
// - Bad frame discarded, old command kept.
// - Output driven only while select low.
// - Thermal flag output before first rising edge.
// - Output changes only on clock rising edge.
// - Clear bit set clears status error bits.
// - Bit fourteen selects bridge group.
// - Bit thirteen sets group open-load shutdown.
// - Bits twelve to seven enable bridges six-one.
// - Bits six to one set high side.
// - Bit zero enables over-voltage lockout.
// - Upper group uses bits ten-seven, four-one.
`timescale 1ns/1ps
module half_bridge_serial_control
(
	input wire logic mclk_i, // system clock, 125 MHz
	input wire logic rst_b_i, // asynchronous reset, active low
	input wire logic sclk_i, // serial clock from the host
	input wire logic frame_select_b_i, // active-low frame select
	input wire logic serial_in_i, // serial input
	output logic serial_out_o, // serial output level
	output logic serial_out_oe_o, // serial output enable
	input wire logic [15:0] status_i, // diagnostic status word
	input wire logic thermal_shutdown_flag_i, // latched thermal flag
	output logic status_clear_o, // one-cycle pulse clearing error bits
	output logic [9:0] bridge_active_o, // per-bridge enable
	output logic [9:0] bridge_high_side_o, // per-bridge drive side
	output logic [1:0] openload_shutdown_enable_o, // per group
	output logic supply_overvoltage_lock_enable_o // lockout enable
);
	logic [15:0] frame_word;
	logic frame_ok;
	logic frame_toggle;
	logic [2:0] toggle_sync;
	logic [2:0] next_toggle_sync;
	logic [15:0] command;
	logic [15:0] next_command;
	wire logic [9:0] active;
	wire logic [9:0] high_side;
	logic [1:0] rst_sync;
	logic [1:0] next_rst_sync;
	logic run_b;
	logic load_any;
	logic load_low;
	logic load_high;
	logic [1:0] olsd;
	logic [1:0] next_olsd;
	logic supply_overvoltage_lock_enable;
	logic next_supply_overvoltage_lock_enable;
	logic clear;
	logic next_clear;
	logic frame_event;

	hb_link_shifter #(.width(hb_serial_pkg::word_bits)) link
	(
		.sclk_i(sclk_i),
		.rst_b_i(rst_b_i),
		.frame_select_b_i(frame_select_b_i),
		.serial_in_i(serial_in_i),
		.status_i(status_i),
		.thermal_shutdown_flag_i(thermal_shutdown_flag_i),
		.serial_out_o(serial_out_o),
		.serial_out_oe_o(serial_out_oe_o),
		.frame_word_o(frame_word),
		.frame_ok_o(frame_ok),
		.frame_toggle_o(frame_toggle)
	);

	// Reset release is brought onto the system clock so that no register
	// leaves reset on a different edge from its neighbours. Assertion stays
	// asynchronous, so the outputs drop at once when reset is applied.
	always_comb
	begin
		next_rst_sync = {rst_sync[0], 1'b1};
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rst_sync <= 2'h0;
		else
			rst_sync <= next_rst_sync;
	end

	assign run_b = rst_sync[1];

	// Toggle crossing; word and verdict are held stable until next frame,
	// which is far longer than the three-cycle crossing delay.
	always_comb
	begin
		next_toggle_sync = {toggle_sync[1:0], frame_toggle};
	end

	always_ff @(posedge mclk_i or negedge run_b)
	begin
		if (!run_b)
			toggle_sync <= 3'h0;
		else
			toggle_sync <= next_toggle_sync;
	end

	// Only the second and third stages are compared, so a metastable first
	// stage can never produce a false or doubled frame event.
	assign frame_event = toggle_sync[2] ^ toggle_sync[1];

	// A word is only accepted when the crossing reports a finished frame
	// with a whole count of words; a bad frame never reaches the command or any output register.
	assign load_any = frame_event && frame_ok;
	assign load_low = load_any &&
		!frame_word[hb_serial_pkg::group_select_pos];
	assign load_high = load_any &&
		frame_word[hb_serial_pkg::group_select_pos];

	// Command word as last accepted.
	always_comb
	begin
		next_command = command;
		if (load_any)
			next_command = frame_word;
	end

	always_ff @(posedge mclk_i or negedge run_b)
	begin
		if (!run_b)
			command <= hb_serial_pkg::command_reset;
		else
			command <= next_command;
	end

	// The clear request is a single pulse per accepted frame; holding it
	// would keep wiping error bits that the diagnostics set again.
	always_comb
	begin
		next_clear = 1'b0;
		if (load_any)
			next_clear = frame_word[
				hb_serial_pkg::status_clear_request_pos];
	end

	always_ff @(posedge mclk_i or negedge run_b)
	begin
		if (!run_b)
			clear <= 1'b0;
		else
			clear <= next_clear;
	end

	// Protection settings. The lockout bit only exists in the lower group
	// word, so an upper group frame leaves it as it was.
	always_comb
	begin
		next_olsd = olsd;
		next_supply_overvoltage_lock_enable = supply_overvoltage_lock_enable;
		if (load_low)
		begin
			next_olsd[0] = frame_word[
				hb_serial_pkg::openload_shutdown_enable_pos];
			next_supply_overvoltage_lock_enable = frame_word[
				hb_serial_pkg::supply_overvoltage_lock_enable_pos];
		end
		if (load_high)
		begin
			next_olsd[1] = frame_word[
				hb_serial_pkg::openload_shutdown_enable_pos];
		end
	end

	always_ff @(posedge mclk_i or negedge run_b)
	begin
		if (!run_b)
		begin
			olsd <= 2'h0;
			supply_overvoltage_lock_enable <= 1'b0;
		end
		else
		begin
			olsd <= next_olsd;
			supply_overvoltage_lock_enable <= next_supply_overvoltage_lock_enable;
		end
	end

	// Per-bridge decode: each bridge knows its group and the positions of
	// its enable and drive bits, and only a frame of its group touches it.
	genvar b;
	generate
		for (b = 0; b < hb_serial_pkg::bridge_count; b++)
		begin : g_bridge
			localparam bit upper = (b >= hb_serial_pkg::low_group_count);
			localparam int slot = upper ?
				b - hb_serial_pkg::low_group_count : b;
			localparam int act_pos = upper ?
				hb_serial_pkg::high_active_lsb + slot :
				hb_serial_pkg::low_active_lsb + slot;
			localparam int hs_pos = upper ?
				hb_serial_pkg::high_high_side_lsb + slot :
				hb_serial_pkg::low_high_side_lsb + slot;
			logic load;
			logic act_q;
			logic next_act;
			logic hs_q;
			logic next_hs;

			assign load = upper ? load_high : load_low;

			always_comb
			begin
				next_act = act_q;
				next_hs = hs_q;
				if (load)
				begin
					next_act = frame_word[act_pos];
					next_hs = frame_word[hs_pos];
				end
			end

			always_ff @(posedge mclk_i or negedge run_b)
			begin
				if (!run_b)
				begin
					act_q <= hb_serial_pkg::bridge_reset[b];
					hs_q <= hb_serial_pkg::bridge_reset[b];
				end
				else
				begin
					act_q <= next_act;
					hs_q <= next_hs;
				end
			end

			assign active[b] = act_q;
			assign high_side[b] = hs_q;
		end
	endgenerate

	assign status_clear_o = clear;
	assign bridge_active_o = active;
	assign bridge_high_side_o = high_side;
	assign openload_shutdown_enable_o = olsd;
	assign supply_overvoltage_lock_enable_o = supply_overvoltage_lock_enable;
endmodule

// >>> src/hb_link_shifter.sv
// Link-clock side shifter: samples serial input and drives serial output.
`timescale 1ns/1ps
module hb_link_shifter
#(
	parameter int width = 16
)
(
	input wire logic sclk_i, // serial clock from the host
	input wire logic rst_b_i, // asynchronous reset, active low
	input wire logic frame_select_b_i, // active-low frame select
	input wire logic serial_in_i, // serial input bit
	input wire logic [width-1:0] status_i, // status word, stable per frame
	input wire logic thermal_shutdown_flag_i, // latched thermal flag
	output logic serial_out_o, // serial output level
	output logic serial_out_oe_o, // serial output enable
	output logic [width-1:0] frame_word_o, // last word shifted in
	output logic frame_ok_o, // frame had a whole count of words
	output logic frame_toggle_o // toggles once per ended frame
);
	logic [width-1:0] shift_in;
	logic [width-1:0] next_shift_in;
	logic [4:0] fall_count;
	logic [4:0] next_fall_count;
	logic seen_word;
	logic next_seen_word;
	logic [width:0] shift_out;
	logic [width:0] next_shift_out;
	logic loaded;

	// Input side: frame select acts as an async reset so each frame starts
	// clean at its falling edge without needing a clock edge first.
	always_comb
	begin
		next_shift_in = {shift_in[width-2:0], serial_in_i};
		next_fall_count = fall_count + 5'h01;
		next_seen_word = seen_word;
		if (fall_count == 5'(width - 1))
		begin
			next_fall_count = 5'h00;
			next_seen_word = 1'b1;
		end
	end

	// A word boundary is remembered beside the count so that a frame with
	// no edges and a frame of whole words can be told apart.
	always_ff @(negedge sclk_i or posedge frame_select_b_i)
	begin
		if (frame_select_b_i)
		begin
			fall_count <= 5'h00;
			seen_word <= 1'b0;
		end
		else
		begin
			shift_in <= next_shift_in;
			fall_count <= next_fall_count;
			seen_word <= next_seen_word;
		end
	end

	// Frame end: capture word and verdict on the rising edge of select.
	// The toggle needs a reset, or the crossing would never see a defined
	// level and no frame could ever be applied.
	always_ff @(posedge frame_select_b_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			frame_word_o <= '0;
			frame_ok_o <= 1'b0;
			frame_toggle_o <= 1'b0;
		end
		else
		begin
			frame_word_o <= shift_in;
			frame_ok_o <= (fall_count == 5'h00) && seen_word;
			frame_toggle_o <= ~frame_toggle_o;
		end
	end

	// Output side: pseudo-bit first, then status MSB first on rising edges.
	always_comb
	begin
		next_shift_out = {shift_out[width-1:0], 1'b0};
		if (!loaded)
			next_shift_out = {status_i, 1'b0};
	end

	always_ff @(posedge sclk_i or posedge frame_select_b_i)
	begin
		if (frame_select_b_i)
		begin
			loaded <= 1'b0;
			shift_out <= '0;
		end
		else
		begin
			loaded <= 1'b1;
			shift_out <= next_shift_out;
		end
	end

	assign serial_out_o = loaded ? shift_out[width] :
		thermal_shutdown_flag_i;
	assign serial_out_oe_o = ~frame_select_b_i;
endmodule

// >>> verif/half_bridge_serial_control_tb.sv
// Self-checking bench for the half-bridge serial control block.
`timescale 1ns/1ps
module half_bridge_serial_control_tb;
	typedef struct {
		logic [15:0] cmd;
		logic [15:0] stat;
		logic [9:0] act;
		logic [9:0] hs;
		logic [1:0] ol;
		logic ov;
	} row_t;
	row_t rows [5] = '{'{16'h3f55, 16'ha5c3, 10'h03e, 10'h02a, 2'h1, 1'b1},
		'{16'hc51e, 16'h3c0f, 10'h2be, 10'h3ea, 2'h1, 1'b1},
		'{16'h2081, 16'h0001, 10'h281, 10'h3c0, 2'h1, 1'b1},
		'{16'h6000, 16'h8000, 10'h001, 10'h000, 2'h3, 1'b1},
		'{16'h0000, 16'hffff, 10'h000, 10'h000, 2'h2, 1'b0}};
	logic mclk, rst_b, sclk, sel_b, din, dout, oe, therm, clr, ov;
	logic [15:0] stat;
	logic [9:0] act, hs;
	logic [1:0] ol;
	logic [16:0] rx;
	int n_mismatch, n_checks, n_clr, c0;
	half_bridge_serial_control dut_u (.mclk_i(mclk), .rst_b_i(rst_b),
		.sclk_i(sclk), .frame_select_b_i(sel_b), .serial_in_i(din),
		.serial_out_o(dout), .serial_out_oe_o(oe), .status_i(stat),
		.thermal_shutdown_flag_i(therm), .status_clear_o(clr),
		.bridge_active_o(act), .bridge_high_side_o(hs),
		.openload_shutdown_enable_o(ol),
		.supply_overvoltage_lock_enable_o(ov));
	hb_host_model host_u (.sclk_o(sclk), .sel_b_o(sel_b), .din_o(din),
		.dout_i(dout));
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (clr === 1'b1)
			n_clr++;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic [31:0] w, input int n,
		input logic [15:0] s, input logic t);
		@(posedge mclk);
		#1;
		stat = s;
		therm = t;
		host_u.xfer(w, n, rx);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		end_sim;
	end
	initial
	begin
		rst_b = 1'b0;
		stat = 16'h0000;
		therm = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		foreach (rows[i])
		begin
			c0 = n_clr;
			run(rows[i].cmd, 16, rows[i].stat, i[0]);
			chk(rx, {i[0], rows[i].stat});
			chk(act, rows[i].act);
			chk(hs, rows[i].hs);
			chk(ol, rows[i].ol);
			if (!rows[i].cmd[14])
				chk(ov, rows[i].ov);
			chk(n_clr - c0, rows[i].cmd[15]);
		end
		run(32'hffff0082, 32, 16'h1234, 1'b1);
		chk({hs, act, ol, ov}, 23'h00200c);
		run(32'h0001ffff, 17, 16'h0000, 1'b0);
		chk({hs, act, ol, ov}, 23'h00200c);
		run(32'h00007fff, 15, 16'h0000, 1'b0);
		chk({hs, act, ol, ov}, 23'h00200c);
		run(32'h0000ffff, 0, 16'h0000, 1'b0);
		chk({hs, act, ol, ov}, 23'h00200c);
		chk(oe, 1'b0);
		rst_b = 1'b0;
		#1 chk({hs, act, ol, ov, clr}, 24'h000000);
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		run(rows[0].cmd, 16, rows[0].stat, 1'b1);
		chk(rx, {1'b1, rows[0].stat});
		chk(act, rows[0].act);
		chk(hs, rows[0].hs);
		end_sim;
	end
endmodule

// >>> verif/hb_host_model.sv
// Host model that frames and shifts words on the serial link.
`timescale 1ns/1ps
module hb_host_model
(
	output logic sclk_o, // serial clock
	output logic sel_b_o, // frame select, active low
	output logic din_o, // data to the device
	input wire logic dout_i // data from the device
);
	initial
	begin
		sclk_o = 1'b0;
		sel_b_o = 1'b1;
		din_o = 1'b0;
	end
	// Data moves 1 ns after the falling edge, clear of the sampling edge.
	task automatic xfer(input logic [31:0] w, input int n,
		output logic [16:0] rx);
		sel_b_o = 1'b0;
		#100;
		rx = {16'h0000, dout_i};
		for (int i = n - 1; i >= 0; i--)
		begin
			din_o = w[i];
			#2 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
			#1 rx = {rx[15:0], dout_i};
		end
		din_o = 1'b0;
		#100 sel_b_o = 1'b1;
		#1000;
	endtask
endmodule

// >>> verif/hb_serial_props.sv
// Port checker for the half-bridge serial control block.
`timescale 1ns/1ps
module hb_serial_props
(
	input wire logic mclk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic sclk_i, // link clock
	input wire logic frame_select_b_i, // select
	input wire logic thermal_shutdown_flag_i, // flag
	input wire logic serial_out_o, // out
	input wire logic serial_out_oe_o, // enable
	input wire logic status_clear_o, // clear
	input wire logic [9:0] bridge_active_o, // active
	input wire logic [9:0] bridge_high_side_o, // side
	input wire logic [1:0] openload_shutdown_enable_o, // cutoff
	input wire logic supply_overvoltage_lock_enable_o // lockout
);
	logic seen_fall;
	logic seen_rise;
	logic out_at_fall;
	logic [22:0] outs;
	assign outs = {bridge_active_o, bridge_high_side_o,
		openload_shutdown_enable_o, supply_overvoltage_lock_enable_o};
	// The first rise of a frame follows the pseudo-bit, so it is skipped.
	always_ff @(negedge sclk_i or posedge frame_select_b_i)
		if (frame_select_b_i)
			seen_fall <= 1'b0;
		else
			seen_fall <= 1'b1;
	always_ff @(posedge sclk_i or posedge frame_select_b_i)
		if (frame_select_b_i)
			seen_rise <= 1'b0;
		else
			seen_rise <= 1'b1;
	// Output level as it stood at the last falling edge of the clock.
	always_ff @(negedge sclk_i)
		out_at_fall <= serial_out_o;
	a_oe_while_sel: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		serial_out_oe_o == !frame_select_b_i) else $error("oe wrong");
	a_out_rise_only: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
		seen_fall && !frame_select_b_i |-> serial_out_o == out_at_fall)
		else $error("out moved");
	a_pseudo_first: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!frame_select_b_i && !$past(frame_select_b_i) && !seen_rise
		|-> serial_out_o == thermal_shutdown_flag_i) else $error("no flag");
	a_hold_in_frame: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!frame_select_b_i && !$past(frame_select_b_i, 5) |-> $stable(outs))
		else $error("changed in frame");
	a_change_sel_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$changed(outs) |-> frame_select_b_i) else $error("early change");
	a_clear_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		status_clear_o |=> !status_clear_o) else $error("long clear");
	a_clear_sel_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		status_clear_o |-> frame_select_b_i && $past(frame_select_b_i, 2))
		else $error("clear in frame");
	a_group_split: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$changed(bridge_active_o[5:0]) |-> $stable(bridge_active_o[9:6]))
		else $error("both groups");
endmodule
bind half_bridge_serial_control hb_serial_props chk_u (.*);
